// ===== asp_pkg.sv
// Purpose: Constants shared by the multichannel audio serial port.
// Assumes: APB register access with 32-bit data on a 250 MHz pclk.
// Notes:   Offsets are byte addresses; fields are bit positions.
package asp_pkg;

  // ------------------------------------------------------------------
  // Register map
  // ------------------------------------------------------------------
  localparam logic [7:0] ASP_CTRL_OFS  = 8'h00;
  localparam logic [7:0] ASP_SLOT_OFS  = 8'h04;
  localparam logic [7:0] ASP_MDIV_OFS  = 8'h08;
  localparam logic [7:0] ASP_STAT_OFS  = 8'h0c;
  localparam logic [7:0] ASP_MEAS_OFS  = 8'h10;
  localparam logic [7:0] ASP_BCAST_OFS = 8'h20;

  // ------------------------------------------------------------------
  // Control, slot and divider fields and reset values
  // ------------------------------------------------------------------
  localparam int CTRL_FMT_POS    = 0;
  localparam int CTRL_WLEN_POS   = 2;
  localparam int CTRL_FSINV_POS  = 4;
  localparam int CTRL_BCINV_POS  = 5;
  localparam int CTRL_MASTER_POS = 6;
  localparam int CTRL_TRI_POS    = 7;
  localparam int CTRL_HOLD_POS   = 8;
  localparam int CTRL_LANE2_POS  = 9;
  localparam int CTRL_LATE_POS   = 10;
  localparam int CTRL_AUTO_POS   = 11;
  localparam int CTRL_OFS_POS    = 12;
  localparam int CTRL_WIDTH      = 17;
  localparam logic [16:0] CTRL_RESET = 17'h0080c;
  localparam int SLOT_LANE_POS   = 6;
  localparam logic [31:0] SLOT_RESET = 32'h00000000;
  localparam int MDIV_RATIO_POS  = 8;
  localparam logic [19:0] MDIV_RESET = 20'h04008;

  // ------------------------------------------------------------------
  // Framing codes
  // ------------------------------------------------------------------
  typedef enum logic [1:0] {
    ASP_FMT_TDM = 2'b00,
    ASP_FMT_I2S = 2'b01,
    ASP_FMT_LJ  = 2'b10,
    ASP_FMT_RSV = 2'b11
  } asp_fmt_type;

  // ------------------------------------------------------------------
  // Clock auto-detect limits
  // ------------------------------------------------------------------
  localparam int PCLK_KHZ      = 250000;
  localparam int FS_MIN_KHZ    = 8;
  localparam int FS_MAX_KHZ    = 768;
  localparam int BCLK_MAX_KHZ  = 24576;
  localparam int RATIO_MIN     = 16;
  localparam int RATIO_MAX     = 2048;
  localparam int FRAME_MAX_CYC = PCLK_KHZ / FS_MIN_KHZ;
  localparam int FRAME_MIN_CYC = PCLK_KHZ / FS_MAX_KHZ;

endpackage

// ===== asp_port.sv
// Purpose: Transmit side of a multichannel I2S / left-justified audio port.
// Assumes: Pin clocks are far slower than pclk; pins pass three flops.
// Notes:   All pins are sampled or driven in the pclk domain.
// What this block does
// - I2S: left slot 0 MSB launches one falling edge after frame sync falls.
// - I2S: right slot 0 MSB launches one falling edge after frame sync rises.
// - Remaining slots of a half-frame follow back to back in order.
// - I2S: frame sync and data change on the falling bit-clock edge.
// - LJ: left slot 0 MSB appears in the cycle frame sync rises.
// - LJ: right slot 0 MSB appears in the cycle frame sync falls.
// - LJ: later data bits and driven frame sync change on falling edges.
// - A broadcast write updates every device on the bus together.
// - Sixty-four assignable slot positions per frame.
// - Optionally release the data line during unassigned slots.
// - Optional bus holder keeps the last value on the data line.
// - A general pin can be a second serial data lane.
// - Optional mode launches data a half cycle later for a full cycle.
// - Port is master generating clocks or slave accepting them.
// - Frame rate and bit-clock ratio are measured to set dividers.
// - Rates 8 to 768 kHz, ratios 16 to 2048, bit clock max 24.576 MHz.
// - Six-bit slot field: 0-31 left slots, 32-63 right slots.
// - Slot start delayed by 0 to 31 bit-clock cycles.
// - Word length 16, 20, 24 or 32 bits, MSB first.
// - Unsupported clocking raises an error; with auto-detect on it also mutes the record data.
module asp_port
  import asp_pkg::*;
#(
  parameter int FRAME_MAX = FRAME_MAX_CYC
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [31:0] ch0_sample,
  input  wire logic [31:0] ch1_sample,
  input  wire logic [31:0] ch2_sample,
  input  wire logic [31:0] ch3_sample,
  input  wire logic        bit_clock_in,
  output logic             bit_clock_out,
  output logic             bit_clock_oe,
  input  wire logic        frame_sync_in,
  output logic             frame_sync_out,
  output logic             frame_sync_oe,
  input  wire logic        serial_data_in,
  output logic             serial_data_out,
  output logic             serial_data_oe,
  output logic             general_pin_one_out,
  output logic             general_pin_one_oe,
  output logic             bus_keeper_out,
  output logic             bus_keeper_en,
  output logic [11:0]      clock_config_ratio,
  output logic [15:0]      clock_config_period,
  output logic             record_mute
);

  // ------------------------------------------------------------------
  // Registers and APB slave
  // ------------------------------------------------------------------
  logic [16:0] ctrl;
  logic [31:0] slots;
  logic [19:0] mdiv;
  logic        clk_err;
  logic [11:0] meas_ratio;
  logic [15:0] meas_period;
  logic        wr_en;
  logic        addr_ok;

  assign wr_en   = psel && penable && pwrite;
  assign addr_ok = paddr inside {ASP_CTRL_OFS, ASP_SLOT_OFS, ASP_MDIV_OFS,
                                 ASP_STAT_OFS, ASP_MEAS_OFS, ASP_BCAST_OFS};
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !addr_ok;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl  <= CTRL_RESET;
      slots <= SLOT_RESET;
      mdiv  <= MDIV_RESET;
    end else if (wr_en) begin
      // The broadcast alias lets one write retune every port at once.
      if (paddr == ASP_CTRL_OFS || paddr == ASP_BCAST_OFS) begin
        ctrl <= pwdata[16:0];
      end
      if (paddr == ASP_SLOT_OFS) begin
        slots <= pwdata;
      end
      if (paddr == ASP_MDIV_OFS) begin
        mdiv <= pwdata[19:0];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (psel && !penable) begin
      unique case (paddr)
        ASP_CTRL_OFS:  prdata <= {15'h0000, ctrl};
        ASP_SLOT_OFS:  prdata <= slots;
        ASP_MDIV_OFS:  prdata <= {12'h000, mdiv};
        ASP_STAT_OFS:  prdata <= {18'h00000, record_mute, clk_err, meas_ratio};
        ASP_MEAS_OFS:  prdata <= {16'h0000, meas_period};
        default:       prdata <= 32'h00000000;
      endcase
    end
  end

  asp_fmt_type fmt;
  logic [1:0]  wl_code;
  logic [4:0]  offset;
  logic        is_i2s;
  logic        port_on;
  logic        master;
  logic        late;
  logic [5:0]  wl_bits;

  assign fmt     = asp_fmt_type'(ctrl[CTRL_FMT_POS +: 2]);
  assign wl_code = ctrl[CTRL_WLEN_POS +: 2];
  assign offset  = ctrl[CTRL_OFS_POS +: 5];
  assign is_i2s  = (fmt == ASP_FMT_I2S);
  assign port_on = (fmt == ASP_FMT_I2S) || (fmt == ASP_FMT_LJ);
  assign master  = ctrl[CTRL_MASTER_POS];
  assign late    = ctrl[CTRL_LATE_POS];

  function automatic logic [5:0] word_bits(input logic [1:0] code);
    unique case (code)
      2'b00: word_bits = 6'd16;
      2'b01: word_bits = 6'd20;
      2'b10: word_bits = 6'd24;
      2'b11: word_bits = 6'd32;
    endcase
  endfunction

  assign wl_bits = word_bits(wl_code);

  // ------------------------------------------------------------------
  // Pin synchronisers and master clock generation
  // ------------------------------------------------------------------
  logic [2:0] bc_s;
  logic [2:0] fs_s;
  logic [2:0] sd_s;
  logic       bc_lvl;
  logic       fs_lvl;
  logic       keep_val;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bc_s     <= 3'h0;
      fs_s     <= 3'h0;
      sd_s     <= 3'h0;
      bc_lvl   <= 1'b0;
      fs_lvl   <= 1'b0;
      keep_val <= 1'b0;
    end else begin
      bc_s <= {bc_s[1:0], bit_clock_in};
      fs_s <= {fs_s[1:0], frame_sync_in};
      sd_s <= {sd_s[1:0], serial_data_in};
      if (bc_s[1] == bc_s[2]) begin
        bc_lvl <= bc_s[2];
      end
      if (fs_s[1] == fs_s[2]) begin
        fs_lvl <= fs_s[2];
      end
      if (sd_s[1] == sd_s[2]) begin
        keep_val <= sd_s[2];
      end
    end
  end

  logic [7:0]  div_cnt;
  logic [7:0]  div_half;
  logic        gen_bclk;
  logic        gen_tick;
  logic [11:0] gen_fcnt;
  logic [11:0] gen_ratio;
  logic [11:0] next_fcnt;
  logic        gen_fs;
  logic        rise_evt;
  logic        fall_evt;

  assign div_half  = (mdiv[7:0] == 8'h00) ? 8'h01 : mdiv[7:0];
  assign gen_ratio = mdiv[MDIV_RATIO_POS +: 12];
  assign gen_tick  = (div_cnt == div_half - 8'h01);
  assign next_fcnt = (gen_fcnt >= gen_ratio - 12'h001) ? 12'h000 : gen_fcnt + 12'h001;

  // Inverting the pin clock swaps which pin edge counts as the fall.
  assign rise_evt = master ? (gen_tick && !gen_bclk) :
                    ((bc_s[1] == bc_s[2]) && (bc_s[2] != bc_lvl) &&
                     (bc_s[2] ^ ctrl[CTRL_BCINV_POS]));
  assign fall_evt = master ? (gen_tick && gen_bclk) :
                    ((bc_s[1] == bc_s[2]) && (bc_s[2] != bc_lvl) &&
                     !(bc_s[2] ^ ctrl[CTRL_BCINV_POS]));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_cnt  <= 8'h00;
      gen_bclk <= 1'b0;
      gen_fcnt <= 12'h000;
      gen_fs   <= 1'b0;
    end else if (master) begin
      div_cnt <= gen_tick ? 8'h00 : div_cnt + 8'h01;
      if (gen_tick) begin
        gen_bclk <= !gen_bclk;
      end
      if (gen_tick && gen_bclk) begin
        // Frame sync moves only on the falling edge of the bit clock.
        gen_fcnt <= next_fcnt;
        gen_fs   <= (next_fcnt < (gen_ratio >> 1)) ? !is_i2s : is_i2s;
      end
    end else begin
      div_cnt  <= 8'h00;
      gen_bclk <= 1'b0;
      gen_fcnt <= 12'h000;
    end
  end

  assign bit_clock_out  = gen_bclk ^ ctrl[CTRL_BCINV_POS];
  assign bit_clock_oe   = master;
  assign frame_sync_out = gen_fs ^ ctrl[CTRL_FSINV_POS];
  assign frame_sync_oe  = master && port_on;

  // ------------------------------------------------------------------
  // Half-frame sequencer
  // ------------------------------------------------------------------
  logic       fs_now;
  logic       fs_prev;
  logic       fs_edge;
  logic       left_now;
  logic       kick;
  logic       armed;
  logic       half;
  logic [5:0] wait_cnt;
  logic [4:0] bitcnt;
  logic [4:0] slot;
  logic       go;

  assign fs_now   = master ? gen_fs : (fs_lvl ^ ctrl[CTRL_FSINV_POS]);
  assign fs_edge  = port_on && (fs_now != fs_prev);
  assign left_now = is_i2s ? !fs_now : fs_now;
  // A zero delay launches at once for LJ; otherwise count falling edges.
  assign go = armed && ((kick && wait_cnt == 6'd0) ||
                        (fall_evt && wait_cnt <= 6'd1));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fs_prev  <= 1'b0;
      kick     <= 1'b0;
      armed    <= 1'b0;
      half     <= 1'b0;
      wait_cnt <= 6'd0;
      bitcnt   <= 5'd0;
      slot     <= 5'd0;
    end else begin
      fs_prev <= fs_now;
      kick    <= fs_edge;
      if (!port_on) begin
        armed <= 1'b0;
      end else if (fs_edge) begin
        armed    <= 1'b1;
        half     <= !left_now;
        wait_cnt <= {1'b0, offset} + {5'd0, is_i2s};
        bitcnt   <= 5'(wl_bits - 6'd1);
        slot     <= 5'd0;
      end else begin
        if (fall_evt && wait_cnt != 6'd0) begin
          wait_cnt <= wait_cnt - 6'd1;
        end
        if (go) begin
          if (bitcnt == 5'd0) begin
            bitcnt <= 5'(wl_bits - 6'd1);
            slot   <= slot + 5'd1;
            if (slot == 5'd31) begin
              armed <= 1'b0;
            end
          end else begin
            bitcnt <= bitcnt - 5'd1;
          end
        end
      end
    end
  end

  // ------------------------------------------------------------------
  // Slot matching and data lanes
  // ------------------------------------------------------------------
  logic [31:0] samp [4];
  logic        main_hit;
  logic        main_bit;
  logic        lane_hit;
  logic        lane_bit;

  function automatic logic pick_bit(input logic [31:0] word, input logic [4:0] pos,
                                    input logic [5:0] wl);
    logic [5:0] idx;
    idx      = 6'({1'b0, pos} + 6'd32 - wl);
    pick_bit = word[idx[4:0]];
  endfunction

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      samp <= '{default: 32'h00000000};
    end else if (fs_edge && left_now) begin
      samp <= '{ch0_sample, ch1_sample, ch2_sample, ch3_sample};
    end
  end

  always_comb begin
    main_hit = 1'b0;
    main_bit = 1'b0;
    lane_hit = 1'b0;
    lane_bit = 1'b0;
    for (int c = 0; c < 4; c++) begin
      // Bit five of the field picks the right half, the rest the slot.
      if (slots[8*c +: 6] == {half, slot}) begin
        if (slots[8*c + SLOT_LANE_POS]) begin
          lane_hit = 1'b1;
          lane_bit = pick_bit(samp[c], bitcnt, wl_bits);
        end else begin
          main_hit = 1'b1;
          main_bit = pick_bit(samp[c], bitcnt, wl_bits);
        end
      end
    end
  end

  // ------------------------------------------------------------------
  // Launch stage and clock auto-detect
  // ------------------------------------------------------------------
  logic [3:0] stage;
  logic [3:0] next_stage;
  logic [3:0] outv;

  assign next_stage = go ? {main_hit, main_bit && !record_mute,
                            lane_hit, lane_bit && !record_mute}
                         : 4'h0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stage <= 4'h0;
      outv  <= 4'h0;
    end else begin
      if (go || fall_evt) begin
        stage <= next_stage;
      end
      // The late mode holds each bit from rise to rise for a full cycle.
      if (late ? rise_evt : (go || fall_evt)) begin
        outv <= late ? stage : next_stage;
      end
    end
  end

  assign serial_data_out     = outv[2];
  assign serial_data_oe      = port_on && (outv[3] || !ctrl[CTRL_TRI_POS]);
  assign general_pin_one_out = outv[0];
  assign general_pin_one_oe  = port_on && ctrl[CTRL_LANE2_POS] &&
                               (outv[1] || !ctrl[CTRL_TRI_POS]);
  assign bus_keeper_out      = keep_val;
  assign bus_keeper_en       = ctrl[CTRL_HOLD_POS] && !serial_data_oe;

  logic [15:0] pcnt;
  logic [11:0] bcnt;
  logic        meas_done;
  logic [31:0] bclk_load;
  logic [31:0] bclk_room;

  assign bclk_load = 32'(meas_ratio) * 32'(PCLK_KHZ);
  assign bclk_room = 32'(meas_period) * 32'(BCLK_MAX_KHZ);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pcnt        <= 16'h0000;
      bcnt        <= 12'h000;
      meas_ratio  <= 12'h000;
      meas_period <= 16'h0000;
      meas_done   <= 1'b0;
      clk_err     <= 1'b0;
    end else begin
      meas_done <= fs_edge && left_now;
      if (fs_edge && left_now) begin
        meas_period <= pcnt;
        meas_ratio  <= bcnt;
        pcnt        <= 16'h0001;
        bcnt        <= 12'h000;
      end else begin
        if (pcnt != 16'hffff) begin
          pcnt <= pcnt + 16'h0001;
        end
        if (rise_evt && bcnt != 12'hfff) begin
          bcnt <= bcnt + 12'h001;
        end
      end
      if (meas_done) begin
        clk_err <= (meas_ratio < 12'(RATIO_MIN)) || (meas_ratio > 12'(RATIO_MAX)) ||
                   (32'(meas_period) > 32'(FRAME_MAX)) ||
                   (meas_period < 16'(FRAME_MIN_CYC)) ||
                   (bclk_load > bclk_room);
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clock_config_ratio  <= 12'h000;
      clock_config_period <= 16'h0000;
    end else if (ctrl[CTRL_AUTO_POS] && meas_done) begin
      clock_config_ratio  <= meas_ratio;
      clock_config_period <= meas_period;
    end
  end

  assign record_mute = clk_err && ctrl[CTRL_AUTO_POS];

  // ------------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_edge_seen;
    fs_edge && !fall_evt;
  endsequence
  sequence s_loaded;
    ##1 wait_cnt == ({1'b0, offset} + {5'd0, is_i2s});
  endsequence

  property p_i2s_one_late;
    (fall_evt && armed && wait_cnt == 6'd1 && !fs_edge && port_on) |-> go;
  endproperty
  a_i2s_one_late: assert property (p_i2s_one_late) else $error("launch missed");

  property p_delay_hold;
    (kick && wait_cnt != 6'd0 && !fall_evt) |-> !go;
  endproperty
  a_delay_hold: assert property (p_delay_hold) else $error("early launch");

  property p_lj_now;
    (kick && armed && wait_cnt == 6'd0) |-> go;
  endproperty
  a_lj_now: assert property (p_lj_now) else $error("LJ MSB late");

  property p_slot_step;
    (go && bitcnt == 5'd0 && slot != 5'd31 && !fs_edge && port_on)
      |=> (slot == $past(slot) + 5'd1) && (bitcnt == 5'(wl_bits - 6'd1));
  endproperty
  a_slot_step: assert property (p_slot_step) else $error("slot order broken");

  property p_load;
    (s_edge_seen and port_on) |-> s_loaded;
  endproperty
  a_load: assert property (p_load) else $error("slot delay not loaded");

  property p_change_edge;
    $changed(serial_data_out) |-> $past(go || fall_evt || rise_evt);
  endproperty
  a_change_edge: assert property (p_change_edge) else $error("data off edge");

  property p_release;
    (fall_evt && !go && !late && ctrl[CTRL_TRI_POS]) |=> !serial_data_oe;
  endproperty
  a_release: assert property (p_release) else $error("line not released");

  property p_mute;
    (go && record_mute && !late) |=> !serial_data_out;
  endproperty
  a_mute: assert property (p_mute) else $error("data not muted");

  property p_low_ratio;
    (meas_done && meas_ratio < 12'(RATIO_MIN)) |=> clk_err;
  endproperty
  a_low_ratio: assert property (p_low_ratio) else $error("ratio error missed");

  property p_bcast;
    (wr_en && paddr == ASP_BCAST_OFS) |=> ctrl == $past(pwdata[16:0]);
  endproperty
  a_bcast: assert property (p_bcast) else $error("broadcast lost");

endmodule // asp_port

// ===== asp_host_model.sv
// Purpose: Host on the audio bus; makes bit clock and frame sync, captures lanes.
// Assumes: Port is slave; 64 bit clocks per half-frame, two 32-bit slots.
// Notes:   Bit clock stands still while run is low.
// The bit clock is slow, so a zero slot-start delay is safe.
module asp_host_model #(
  parameter int HALF = 8
) (
  input  wire logic   pclk,
  input  wire logic   run,
  input  wire logic   i2s,
  input  wire logic   data_line,
  input  wire logic   lane_line,
  input  wire logic   data_oe,
  output logic        bit_clock,
  output logic        frame_sync,
  output logic [63:0] left_bits,
  output logic [63:0] right_bits,
  output logic [63:0] lane_left,
  output logic [7:0]  drive_left,
  output logic [15:0] halves
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0]  cnt = 8'h00;
  logic [15:0] ph = 16'h0000;
  logic [63:0] sh;
  logic [63:0] lsh;
  logic [7:0]  drv;
  initial begin
    bit_clock = 1'b0;
    frame_sync = 1'b0;
    halves = 16'h0000;
  end
  // ------------------------------------------------------------------
  // Frame sync flips on a falling edge after 64 bit clocks.
  // ------------------------------------------------------------------
  always @(posedge pclk) begin
    if (run && ph == HALF - 1) begin
      ph <= 16'h0000;
      bit_clock <= ~bit_clock;
      if (bit_clock && cnt == 8'd64) begin
        cnt <= 8'h00;
        frame_sync <= ~frame_sync;
      end
      if (!bit_clock) begin
        cnt <= cnt + 8'h01;
        sh <= {sh[62:0], data_line};
        lsh <= {lsh[62:0], lane_line};
        drv <= (cnt == 8'h00 ? 8'h00 : drv) + {7'h00, data_oe};
        if (cnt == (i2s ? 8'h00 : 8'h3f)) begin
          halves <= halves + 16'h0001;
          if (frame_sync) begin
            left_bits <= {sh[62:0], data_line};
            lane_left <= {lsh[62:0], lane_line};
            drive_left <= drv + {7'h00, data_oe};
          end else begin
            right_bits <= {sh[62:0], data_line};
          end
        end
      end
    end else if (run) begin
      ph <= ph + 16'h0001;
    end
  end
endmodule // asp_host_model

// ===== multichannel_i2s_lj_audio_port_bench.sv
// Purpose: Self-checking bench of the audio serial port in slave mode.
// Assumes: Host model supplies the clocks; released lines idle high unless the bus holder keeps the data line.
// Notes:   Register rows first, then LJ, I2S and a reset in mid-run.
module multichannel_i2s_lj_audio_port_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import asp_pkg::*;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic        pready, pslverr, e, run = 1'b0, i2s = 1'b0;
  logic [31:0] c0 = 32'ha5c30f96, c1 = 32'h3c5a9617, c2 = 32'hf00dc0de, c3 = 32'h81e74b2d;
  logic        bo, boe, fo, foe, so, soe, go, goe, ko, ken, mb, mf, sl, gl;
  logic [11:0] ratio;
  logic [15:0] period, halves;
  logic        mute;
  logic [63:0] lb, rb, ll;
  logic [7:0]  dl;
  int          num_errors = 0, check_count = 0;
  logic [80:0] rows [4] = '{{8'h04, 8'h04, 32'h41202100, 32'h41202100, 1'b0},
    {8'h08, 8'h08, 32'h00080008, 32'h00080008, 1'b0}, {8'h10, 8'h10, 32'hffff, 32'h0, 1'b0},
    {8'h30, 8'h30, 32'h1, 32'h0, 1'b1}};
  assign sl = soe ? so : (ken ? ko : 1'b1);
  assign gl = goe ? go : 1'b1;
  asp_port #(.FRAME_MAX(4000)) dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .ch0_sample(c0), .ch1_sample(c1), .ch2_sample(c2),
    .ch3_sample(c3), .bit_clock_in(boe ? bo : mb), .bit_clock_out(bo), .bit_clock_oe(boe),
    .frame_sync_in(foe ? fo : mf), .frame_sync_out(fo), .frame_sync_oe(foe),
    .serial_data_in(sl), .serial_data_out(so), .serial_data_oe(soe),
    .general_pin_one_out(go), .general_pin_one_oe(goe), .bus_keeper_out(ko),
    .bus_keeper_en(ken), .clock_config_ratio(ratio), .clock_config_period(period),
    .record_mute(mute));
  asp_host_model #(.HALF(8)) host_u (.pclk(pclk), .run(run), .i2s(i2s), .data_line(sl),
    .lane_line(gl), .data_oe(soe), .bit_clock(mb), .frame_sync(mf), .left_bits(lb),
    .right_bits(rb), .lane_left(ll), .drive_left(dl), .halves(halves));
  initial begin
    forever #2 pclk = ~pclk;
  end
  task check_word(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task stop_test;
    $display("errors=%0d checks=%0d", num_errors, check_count);
    if (num_errors == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  task wait_halves(input int n);
    int h0;
    h0 = halves;
    while (halves < h0 + n) @(posedge pclk);
  endtask
  task lane_checks;
    check_word(lb[63:32], c0);
    check_word(rb[63:32], c2);
    check_word(rb[31:0], c1);
    check_word(ll[31:0], c3);
  endtask
  initial begin
    #200000;
    num_errors++;
    stop_test();
  end
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, 8'h00, 32'h0);
    check_word(q, 32'h0000080c);
    check_word({31'h0, soe}, 32'h0);
    foreach (rows[i]) begin
      apb(1'b1, rows[i][80:73], rows[i][64:33]);
      apb(1'b0, rows[i][72:65], 32'h0);
      check_word(q, rows[i][32:1]);
      check_word({31'h0, e}, {31'h0, rows[i][0]});
    end
    apb(1'b1, 8'h20, 32'h00000a8e);
    apb(1'b0, 8'h00, 32'h0);
    check_word(q, 32'h00000a8e);
    run <= 1'b1;
    wait_halves(6);
    lane_checks();
    check_word({24'h0, dl}, 32'd32);
    check_word(lb[31:0], 32'hffffffff);
    check_word({20'h0, ratio}, 32'd128);
    check_word({16'h0, period}, 32'd2048);
    check_word({31'h0, mute}, 32'h0);
    run <= 1'b0;
    i2s <= 1'b1;
    apb(1'b1, 8'h00, 32'h00000b8d);
    run <= 1'b1;
    wait_halves(6);
    lane_checks();
    check_word(lb[31:0], {32{c0[0]}});
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    check_word({31'h0, soe}, 32'h0);
    presetn <= 1'b1;
    apb(1'b0, 8'h00, 32'h0);
    check_word(q, 32'h0000080c);
    stop_test();
  end
endmodule // multichannel_i2s_lj_audio_port_bench
